// File: bench/gdc_host_model.sv
// host model driving the enable and phase pins
`timescale 1ns/1ps
module gdc_host_model (
  input  wire logic       clock,
  input  wire logic       oe_cmd,
  input  wire logic [5:0] phase_cmd,
  input  wire logic [5:0] float_cmd,
  output logic            output_enable,
  output logic [5:0]      phase_in,
  output logic [5:0]      phase_driven
);
  // pins quiet until the first edge
  initial
  begin
    output_enable = 1'b0;
    phase_in = 6'h00;
    phase_driven = 6'h3F;
  end
  // pins follow commands one edge later; released pins show a toggling level
  always @(posedge clock)
  begin
    output_enable <= oe_cmd;
    phase_in <= (phase_cmd & ~float_cmd) | (~phase_in & float_cmd);
    phase_driven <= ~float_cmd;
  end
endmodule // gdc_host_model

// File: bench/tb.sv
// self-checking bench for the gate drive state and fault control
`timescale 1ns/1ps
module tb;
  logic                 clock, reset_n, oe_cmd, output_enable, wr, rd;
  logic                 fault_n_out, fault_n_oe;
  logic [5:0]           phase_cmd, float_cmd, phase_in, phase_driven, gate_out;
  logic [3:0]           addr;
  logic [7:0]           wdata, rdata, rv;
  gdc_pkg::gdc_cond_t   cond;
  gdc_pkg::gdc_blocks_t blocks;
  int                   err_total, checked;

  gdc_host_model gdc_host_model_i (.clock(clock), .oe_cmd(oe_cmd), .phase_cmd(phase_cmd),
    .float_cmd(float_cmd), .output_enable(output_enable), .phase_in(phase_in),
    .phase_driven(phase_driven));
  gdc_ctrl gdc_ctrl_i (.clock(clock), .reset_n(reset_n), .output_enable(output_enable),
    .phase_in(phase_in), .phase_driven(phase_driven), .cond(cond), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .gate_out(gate_out),
    .fault_n_out(fault_n_out), .fault_n_oe(fault_n_oe), .blocks(blocks));

  // 10 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic host(input logic oe, input logic [5:0] ph, input logic [5:0] fl);
    @(posedge clock);
    oe_cmd <= oe;
    phase_cmd <= ph;
    float_cmd <= fl;
  endtask

  task automatic print_verdict;
    if (err_total == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // power-up values, pass-through and masking of released pins
  task automatic t_basic;
    cyc(3);
    chk({1'b0, blocks}, 8'h3F);
    chk({6'h00, fault_n_oe, fault_n_out}, 8'h00);
    rchk(gdc_pkg::ADDR_FIRST_CONFIG_REGISTER, 8'h01);
    rchk(gdc_pkg::ADDR_STATUS0, 8'h20);
    wr_reg(4'hF, 8'hFF);
    rchk(4'hF, 8'h00);
    host(1'b1, 6'h2D, 6'h00);
    cyc(4);
    chk({2'b00, gate_out}, 8'h2D);
    host(1'b1, 6'h3F, 6'h0F);
    cyc(4);
    chk({2'b00, gate_out}, 8'h30);
    cyc(1);
    chk({2'b00, gate_out}, 8'h30);
  endtask

  // gate-bias fault: gating, latching and clearing
  task automatic t_bias;
    host(1'b1, 6'h00, 6'h00);
    cond.bias_low <= 1'b1;
    cyc(30);
    chk({7'h00, fault_n_oe}, 8'h00);
    wr_reg(gdc_pkg::ADDR_FIRST_CONFIG_REGISTER, 8'h00);
    host(1'b1, 6'h07, 6'h00);
    cyc(30);
    chk({1'b0, fault_n_oe, gate_out}, 8'h07);
    wr_reg(gdc_pkg::ADDR_FIRST_CONFIG_REGISTER, 8'h01);
    cyc(20);
    chk({1'b0, fault_n_oe, gate_out}, 8'h40);
    rchk(gdc_pkg::ADDR_STATUS1, 8'h04);
    rchk(gdc_pkg::ADDR_STATUS0, 8'h21);
    @(posedge clock);
    cond.bias_low <= 1'b0;
    cyc(20);
    chk({1'b0, fault_n_oe, gate_out}, 8'h40);
    @(posedge clock);
    cond.bias_low <= 1'b1;
    host(1'b0, 6'h07, 6'h00);
    cyc(4);
    host(1'b1, 6'h07, 6'h00);
    cyc(5);
    chk({1'b0, fault_n_oe, gate_out}, 8'h40);
    @(posedge clock);
    cond.bias_low <= 1'b0;
    host(1'b0, 6'h07, 6'h00);
    cyc(3);
    chk({2'b00, gate_out}, 8'h00);
    host(1'b1, 6'h07, 6'h00);
    cyc(5);
    chk({1'b0, fault_n_oe, gate_out}, 8'h07);
    rchk(gdc_pkg::ADDR_STATUS1, 8'h00);
  endtask

  // standby after a long enable-low, then sleep and wake
  task automatic t_low_power;
    host(1'b0, 6'h07, 6'h00);
    cyc(10010);
    chk({1'b0, blocks}, 8'h27);
    chk({2'b00, gate_out}, 8'h00);
    wr_reg(gdc_pkg::ADDR_FIRST_CONFIG_REGISTER, 8'h41);
    cyc(2);
    chk({1'b0, blocks}, 8'h25);
    wr_reg(gdc_pkg::ADDR_FIRST_CONFIG_REGISTER, 8'h03);
    cyc(5);
    chk({1'b0, blocks}, 8'h40);
    @(posedge clock);
    cond.wake <= 1'b1;
    cyc(3);
    @(posedge clock);
    cond.wake <= 1'b0;
    cyc(5);
    chk({1'b0, blocks}, 8'h27);
    rchk(gdc_pkg::ADDR_STATUS0, 8'h60);
    rchk(gdc_pkg::ADDR_FIRST_CONFIG_REGISTER, 8'h01);
    wr_reg(gdc_pkg::ADDR_CONTROL, 8'h02);
    rchk(gdc_pkg::ADDR_STATUS0, 8'h00);
    host(1'b1, 6'h07, 6'h00);
    cyc(5);
    chk({1'b0, blocks}, 8'h3F);
  endtask

  // overtemperature shutdown and delayed link shutdown
  // supply shutdown: configuration lost, power status set
  task automatic t_supply;
    wr_reg(gdc_pkg::ADDR_FIRST_CONFIG_REGISTER, 8'h41);
    @(posedge clock);
    cond.supply_low <= 1'b1;
    cyc(2);
    @(posedge clock);
    cond.supply_low <= 1'b0;
    cyc(2);
    rchk(gdc_pkg::ADDR_FIRST_CONFIG_REGISTER, 8'h01);
    rchk(gdc_pkg::ADDR_STATUS0, 8'h40);
  endtask

  task automatic t_overtemp;
    @(posedge clock);
    cond.overtemp <= 1'b1;
    cyc(5);
    chk({1'b0, blocks}, 8'h05);
    chk({2'b00, gate_out}, 8'h00);
    wr_reg(gdc_pkg::ADDR_CONTROL, 8'h01);
    cyc(49985);
    chk({1'b0, blocks}, 8'h05);
    cyc(30);
    chk({1'b0, blocks}, 8'h01);
  endtask

  // main sequence
  initial
  begin
    {reset_n, wr, rd, addr, wdata, phase_cmd, float_cmd, cond} = '0;
    oe_cmd = 1'b1;
    err_total = 0;
    checked = 0;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    t_basic;
    t_bias;
    t_low_power;
    t_supply;
    t_overtemp;
    print_verdict;
  end

  // watchdog against a hang
  initial
  begin
    repeat (80000) @(posedge clock);
    err_total++;
    print_verdict;
  end
endmodule // tb

// File: src/gdc_ctrl.sv
// gate drive state machine, gate gating and gate-bias fault latch
// Operation
// RQ1 - sleep: all off except wake latch
// RQ2 - standby: regulator, link, monitors on; drivers off
// RQ3 - overtemp: power off, link off after 5ms
// RQ4 - power status set at power-up, shutdown, wake
// RQ5 - gate follows its phase input
// RQ6 - undriven phase input reads low
// RQ7 - gates low on fault, sleep, enable-low
// RQ8 - bias checked only while driving
// RQ9 - filtered bias low blocks driver turn-on
// RQ10 - bias fault pulls indicator, sets status1
// RQ11 - bias fault latched until enable toggles
// RQ12 - bias check gated by config bit
// RQ13 - enable rise clears only ceased faults
// RQ14 - enable low over 1ms enters standby
// RQ15 - enable high, no fault: all on; the code leaves the wake latch off
`timescale 1ns/1ps
module gdc_ctrl (
  input  wire logic                 clock,
  input  wire logic                 reset_n,
  input  wire logic                 output_enable,
  input  wire logic [5:0]           phase_in,
  input  wire logic [5:0]           phase_driven,
  input  wire gdc_pkg::gdc_cond_t   cond,
  input  wire logic [3:0]           addr,
  input  wire logic [7:0]           wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic [7:0]                rdata,
  output logic [5:0]                gate_out,
  output logic                      fault_n_out,
  output logic                      fault_n_oe,
  output gdc_pkg::gdc_blocks_t      blocks
);

  gdc_pkg::gdc_state_t state;
  gdc_pkg::gdc_state_t next_state;
  logic [7:0]  first_config_register;
  logic [2:0]  pwr_status;
  logic        ot_flag;
  logic        bias_flag;
  logic        oe_prev;
  logic        msg_sent;
  logic [15:0] oe_low_cnt;
  logic [15:0] link_cnt;
  logic [7:0]  bias_cnt;
  logic [5:0]  gate_q;

  // decoding
  wire sel_cfg     = wr && (addr == gdc_pkg::ADDR_FIRST_CONFIG_REGISTER);
  wire sel_ctl     = wr && (addr == gdc_pkg::ADDR_CONTROL);
  wire sleep_req   = first_config_register[gdc_pkg::CFG_SLEEP_BIT];
  wire bias_enable = first_config_register[gdc_pkg::CFG_BIAS_CHECK_BIT];
  wire oe_rise     = output_enable && !oe_prev;
  wire oe_timeout  = (oe_low_cnt >= 16'(gdc_pkg::OE_STANDBY_CYC));
  wire any_fault   = ot_flag || bias_flag;
  wire link_done   = (link_cnt >= 16'(gdc_pkg::LINK_OFF_CYC));
  wire [5:0] phase_clean = phase_in & phase_driven;   // RQ6
  wire driving     = |gate_q;
  wire bias_trip   = bias_enable && driving && cond.bias_low        // RQ8 RQ12
                     && (bias_cnt >= 8'(gdc_pkg::BIAS_FILTER_CYC)); // RQ9
  wire drive_ok    = (state == gdc_pkg::GDC_OPERATE) && !any_fault && !bias_trip;

  // next system state
  always_comb
  begin
    next_state = state;
    case (state)
      gdc_pkg::GDC_OPERATE:
        if (any_fault) next_state = gdc_pkg::GDC_FAULT;
        else if (!output_enable) next_state = gdc_pkg::GDC_WAIT;
      gdc_pkg::GDC_WAIT:
        if (output_enable) next_state = any_fault ? gdc_pkg::GDC_FAULT : gdc_pkg::GDC_OPERATE;
        else if (sleep_req) next_state = gdc_pkg::GDC_SLEEP;
        else if (oe_timeout) next_state = gdc_pkg::GDC_STANDBY; // RQ14
      gdc_pkg::GDC_STANDBY:
        if (sleep_req) next_state = gdc_pkg::GDC_SLEEP;
        else if (output_enable) next_state = gdc_pkg::GDC_OPERATE;
      gdc_pkg::GDC_SLEEP:
        if (cond.wake) next_state = gdc_pkg::GDC_STANDBY;
      gdc_pkg::GDC_FAULT:
        if (!output_enable && sleep_req) next_state = gdc_pkg::GDC_SLEEP;
        else if (oe_rise && !cond.overtemp && !cond.bias_low)
          next_state = gdc_pkg::GDC_OPERATE;
      default:
        next_state = gdc_pkg::GDC_OPERATE;
    endcase
  end

  // state register and enable-low timer
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      state      <= gdc_pkg::GDC_OPERATE;
      oe_prev    <= 1'b0;
      oe_low_cnt <= 16'h0000;
    end
    else
    begin
      state      <= next_state;
      oe_prev    <= output_enable;
      oe_low_cnt <= output_enable ? 16'h0000 : (oe_timeout ? oe_low_cnt : oe_low_cnt + 16'h0001);
    end
  end

  // configuration; lost on sleep wake and supply shutdown
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      first_config_register <= gdc_pkg::FIRST_CONFIG_REGISTER_RESET;
    else if (cond.supply_low || (state == gdc_pkg::GDC_SLEEP && cond.wake))
      first_config_register <= gdc_pkg::FIRST_CONFIG_REGISTER_RESET; // RQ4
    else if (sel_cfg)
      first_config_register <= wdata;
  end

  // power status: hardware set wins over software acknowledge
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      pwr_status <= gdc_pkg::PWR_POR; // RQ4
    else if (cond.supply_low)
      pwr_status <= gdc_pkg::PWR_SUPPLY_LOW_SHUTDOWN; // RQ4
    else if (state == gdc_pkg::GDC_SLEEP && cond.wake)
      pwr_status <= gdc_pkg::PWR_SLEEP; // RQ4
    else if (cond.overtemp && !ot_flag)
      pwr_status <= gdc_pkg::PWR_OTSHDN;
    else if (sel_ctl && wdata[gdc_pkg::CTRL_PACK_BIT])
      pwr_status <= gdc_pkg::PWR_NORMAL;
  end

  // fault latches, cleared on enable rise only if ceased
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      ot_flag   <= 1'b0;
      bias_flag <= 1'b0;
    end
    else
    begin
      ot_flag   <= cond.overtemp || (ot_flag && !oe_rise); // RQ13
      bias_flag <= bias_trip || (bias_flag && !(oe_rise && !cond.bias_low)); // RQ11 RQ13
    end
  end

  // bias filter counter and overtemp link timer
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      bias_cnt <= 8'h00;
      msg_sent <= 1'b0;
      link_cnt <= 16'h0000;
    end
    else
    begin
      if (bias_enable && driving && cond.bias_low) // RQ8
        bias_cnt <= (bias_cnt == 8'hFF) ? bias_cnt : bias_cnt + 8'h01;
      else
        bias_cnt <= 8'h00;
      if (!ot_flag)
        msg_sent <= 1'b0;
      else if (sel_ctl && wdata[gdc_pkg::CTRL_MSG_BIT])
        msg_sent <= 1'b1;
      if (!ot_flag || !msg_sent)
        link_cnt <= 16'h0000;
      else if (!link_done)
        link_cnt <= link_cnt + 16'h0001; // RQ3
    end
  end

  // gate outputs: phase pass-through when allowed
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      gate_q <= 6'h00;
    else
      gate_q <= drive_ok ? phase_clean : 6'h00; // RQ5 RQ7 RQ9 RQ15
  end
  assign gate_out = gate_q;

  // open-drain fault indicator
  assign fault_n_out = 1'b0;
  assign fault_n_oe  = any_fault; // RQ10

  // block power map per state
  always_comb
  begin
    blocks = '0;
    case (state)
      gdc_pkg::GDC_OPERATE, gdc_pkg::GDC_WAIT:
        blocks = 7'h7F ^ 7'h40; // RQ15
      gdc_pkg::GDC_STANDBY:
      begin
        blocks.logic_reg = 1'b1; // RQ2
        blocks.host_link = 1'b1;
        blocks.monitors  = 1'b1;
        blocks.op_amps   = !first_config_register[gdc_pkg::CFG_AMP_OFF_BIT];
      end
      gdc_pkg::GDC_SLEEP:
        blocks.wake_latch = 1'b1; // RQ1
      gdc_pkg::GDC_FAULT:
      begin
        blocks.monitors  = 1'b1;
        if (ot_flag)
          blocks.host_link = !link_done; // RQ3
        else
        begin
          blocks.logic_reg = 1'b1;
          blocks.boot_reg  = 1'b1;
          blocks.host_link = 1'b1;
          blocks.op_amps   = 1'b1;
        end
      end
      default:
        blocks = '0;
    endcase
  end

  // register read, one cycle later
  wire [7:0] st0 = {pwr_status, 2'b00, ot_flag, 1'b0, any_fault};
  wire [7:0] st1 = {5'b00000, bias_flag, 2'b00};
  wire [7:0] rd_mux =
    (addr == gdc_pkg::ADDR_FIRST_CONFIG_REGISTER)    ? first_config_register :
    (addr == gdc_pkg::ADDR_STATUS0) ? st0 :
    (addr == gdc_pkg::ADDR_STATUS1) ? st1 : // RQ10
    (addr == gdc_pkg::ADDR_BLOCKS)  ? {1'b0, blocks} : 8'h00;
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      rdata <= 8'h00;
    else
      rdata <= rd ? rd_mux : 8'h00;
  end

  // checks
  a_gates_fault_off: assert property (@(posedge clock) disable iff (!reset_n)
    any_fault |=> gate_out == 6'h00) else $error("gates active during fault"); // RQ7
  a_gates_standby: assert property (@(posedge clock) disable iff (!reset_n)
    state == gdc_pkg::GDC_STANDBY |-> gate_out == 6'h00) else $error("gates on in standby"); // RQ2
  a_sleep_blocks: assert property (@(posedge clock) disable iff (!reset_n)
    state == gdc_pkg::GDC_SLEEP |-> blocks == 7'h40) else $error("sleep blocks wrong"); // RQ1
  a_pass_through: assert property (@(posedge clock) disable iff (!reset_n)
    drive_ok |=> gate_out == $past(phase_clean)) else $error("phase not passed"); // RQ5
  a_undriven_low: assert property (@(posedge clock) disable iff (!reset_n)
    (phase_driven == 6'h00) |=> gate_out == 6'h00) else $error("undriven gate on"); // RQ6
  a_bias_latch: assert property (@(posedge clock) disable iff (!reset_n)
    bias_flag && !oe_rise |=> bias_flag) else $error("bias fault lost"); // RQ11
  a_bias_pin: assert property (@(posedge clock) disable iff (!reset_n)
    bias_flag |-> fault_n_oe && st1[gdc_pkg::ST1_BIAS_BIT]) else $error("bias not shown"); // RQ10
  a_bias_gated: assert property (@(posedge clock) disable iff (!reset_n)
    !bias_enable |=> !$rose(bias_flag)) else $error("bias check not gated"); // RQ12
  a_standby_entry: assert property (@(posedge clock) disable iff (!reset_n)
    state == gdc_pkg::GDC_WAIT && oe_timeout && !output_enable && !sleep_req
    |=> state == gdc_pkg::GDC_STANDBY) else $error("standby not entered"); // RQ14
  a_clear_held: assert property (@(posedge clock) disable iff (!reset_n)
    bias_flag && oe_rise && cond.bias_low |=> bias_flag) else $error("active fault cleared"); // RQ13
  a_link_off: assert property (@(posedge clock) disable iff (!reset_n)
    state == gdc_pkg::GDC_FAULT && ot_flag && link_done |-> !blocks.host_link)
    else $error("link on after delay"); // RQ3

  c_standby: cover property (@(posedge clock) state == gdc_pkg::GDC_STANDBY);
  c_sleep: cover property (@(posedge clock) state == gdc_pkg::GDC_SLEEP);
  c_bias_trip: cover property (@(posedge clock) $rose(bias_flag));
  c_fault_clear: cover property (@(posedge clock) $fell(bias_flag));

endmodule // gdc_ctrl

// File: src/gdc_pkg.sv
// package of constants and carriers for the gate drive state and fault control
package gdc_pkg;

  // clock rate and timing
  localparam int unsigned CLK_HZ            = 10_000_000;
  localparam int unsigned OE_STANDBY_US     = 1000;   // enable-low time before standby, us
  localparam int unsigned LINK_OFF_US       = 5000;   // overtemp link shutdown delay, us
  localparam int unsigned BIAS_FILTER_NS    = 1000;   // gate-bias filter time, ns
  localparam int unsigned OE_STANDBY_CYC    = OE_STANDBY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned LINK_OFF_CYC      = LINK_OFF_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BIAS_FILTER_CYC   =
    (BIAS_FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // register offsets
  localparam logic [3:0] ADDR_FIRST_CONFIG_REGISTER     = 4'h0;
  localparam logic [3:0] ADDR_STATUS0  = 4'h1;
  localparam logic [3:0] ADDR_STATUS1  = 4'h2;
  localparam logic [3:0] ADDR_BLOCKS   = 4'h3;
  localparam logic [3:0] ADDR_CONTROL  = 4'h4;

  // first_config_register fields
  localparam int unsigned CFG_BIAS_CHECK_BIT = 0; // gate_bias_check_enable
  localparam int unsigned CFG_SLEEP_BIT      = 1; // low-power request
  localparam int unsigned CFG_AMP_OFF_BIT    = 6; // op amps off in standby
  localparam logic [7:0]  FIRST_CONFIG_REGISTER_RESET         = 8'h01;

  // status fields
  localparam int unsigned ST0_FAULT_BIT  = 0;
  localparam int unsigned ST0_OT_BIT     = 2;
  localparam int unsigned ST0_PWR_LSB    = 5;
  localparam int unsigned ST1_BIAS_BIT   = 2;
  localparam int unsigned CTRL_MSG_BIT   = 0; // overtemp message sent
  localparam int unsigned CTRL_PACK_BIT  = 1; // power status acknowledge

  // power status codes
  localparam logic [2:0] PWR_NORMAL = 3'h0;
  localparam logic [2:0] PWR_POR    = 3'h1;
  localparam logic [2:0] PWR_SUPPLY_LOW_SHUTDOWN = 3'h2;
  localparam logic [2:0] PWR_SLEEP  = 3'h3;
  localparam logic [2:0] PWR_OTSHDN = 3'h5;

  // system states
  typedef enum logic [4:0] {
    GDC_OPERATE = 5'h01,
    GDC_WAIT    = 5'h02,
    GDC_STANDBY = 5'h04,
    GDC_SLEEP   = 5'h08,
    GDC_FAULT   = 5'h10
  } gdc_state_t;

  // internal block power enables
  typedef struct packed {
    logic wake_latch;
    logic logic_reg;
    logic boot_reg;
    logic drivers;
    logic host_link;
    logic op_amps;
    logic monitors;
  } gdc_blocks_t;

  // fault and event conditions
  typedef struct packed {
    logic overtemp;
    logic supply_low;
    logic bias_low;
    logic wake;
  } gdc_cond_t;

endpackage
